// ### include/dsf_pkg.sv
// constants and types shared by the decimating symmetric filter files
package dsf_pkg;
    // widths
    localparam int DW      = 10;           // sample width
    localparam int CW      = 10;           // coefficient width
    localparam int AW      = 9;            // config address width
    localparam int SSW     = 5;            // coefficient set select width
    localparam int PREW    = DW + 1;       // pre-adder width
    localparam int PRODW   = PREW + CW;    // product width
    localparam int SOPW    = PRODW + 2;    // sum of four products
    localparam int ACCW    = SOPW + 4;     // sixteen clocks of growth
    localparam int OW      = ACCW + 1;     // output word, holds a + b

    // structure
    localparam int CELLS      = 2;
    localparam int TAPS       = 4;         // multipliers per cell
    localparam int MAX_DEC    = 16;
    localparam int LINE_LEN   = TAPS * MAX_DEC;
    localparam int SET_WORDS  = 8;
    localparam int COEF_DEPTH = 256;
    localparam int FIFO_DEPTH = 32;

    // register offsets on the config address bus
    localparam logic [AW-1:0] OFS_MODE = 9'h000;
    localparam logic [AW-1:0] OFS_AUX  = 9'h001;
    localparam logic [AW-1:0] OFS_COEF = 9'h100;

    // filter_mode_config fields
    localparam int MODE_DEC_LSB    = 0;
    localparam int MODE_DEC_W      = 4;
    localparam int MODE_EVEN_A_BIT = 6;
    localparam int MODE_EVEN_B_BIT = 7;
    localparam int MODE_SYM_BIT    = 8;

    // filter_aux_config fields
    localparam int AUX_REV_DIS_BIT = 4;

    // values after reset
    localparam logic [9:0] MODE_RST = 10'h000;
    localparam logic [9:0] AUX_RST  = 10'h000;

    // output select codes
    localparam logic [1:0] SEL_A   = 2'h0;
    localparam logic [1:0] SEL_B   = 2'h1;
    localparam logic [1:0] SEL_SUM = 2'h2;

    // output sequencing
    typedef enum logic [0:0] {
        OS_IDLE   = 1'b0,
        OS_SECOND = 1'b1
    } dsf_oseq_t;
endpackage : dsf_pkg

// ### rtl/dsf_fifo.sv
// output buffer with valid and ready on both sides
`timescale 1ns/1ps
module dsf_fifo #(
    parameter int W     = 28,
    parameter int DEPTH = 32
) (
    input  wire logic         clock,     // system clock
    input  wire logic         rstn,      // synchronous reset, low
    input  wire logic [W-1:0] in_data,   // word to store
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    output logic [W-1:0]      out_data,  // oldest word
    output logic              out_valid, // buffer not empty
    input  wire logic         out_ready  // consumer takes word
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW:0]  wr_r;
    logic [PW:0]  wr_nxt;
    logic [PW:0]  rd_r;
    logic [PW:0]  rd_nxt;
    logic         push;
    logic         pop;

    // extra pointer bit tells full from empty
    assign in_ready  = !((wr_r[PW] != rd_r[PW]) &&
                         (wr_r[PW-1:0] == rd_r[PW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign out_data  = mem_r[rd_r[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (push) begin
            wr_nxt = wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = rd_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // storage carries no reset; only words behind the pointers are read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r[PW-1:0]] <= in_data;
        end
    end
endmodule : dsf_fifo

// ### rtl/dsf_decim_fir.sv
// dual symmetric fir cell pair with decimation, lifo reversal and output mux
`timescale 1ns/1ps

module dsf_decim_fir (
    input  wire logic                    clock,              // 100 MHz
    input  wire logic                    rstn,               // sync, low
    input  wire logic [dsf_pkg::DW-1:0]  data_a_in,          // cell A sample
    input  wire logic [dsf_pkg::DW-1:0]  data_b_in,          // cell B sample
    output logic                         sample_ready,       // low: hold
    input  wire logic                    lifo_swap_strobe,   // bank swap
    input  wire logic                    accumulate_control, // high: sum on
    input  wire logic [dsf_pkg::SSW-1:0] coef_set_select,    // set 0..31
    input  wire logic [1:0]              output_select,      // a, b, sum
    input  wire logic [9:0]              config_data_bus,    // write data
    input  wire logic [dsf_pkg::AW-1:0]  config_address_bus, // write addr
    input  wire logic                    config_wr_n,        // strobe, low
    output logic [dsf_pkg::OW-1:0]       out_data,           // result word
    output logic                         out_valid,          // word ready
    input  wire logic                    out_ready           // sink takes
);
    // configuration registers and coefficient bank
    logic [9:0]                    mode_r;
    logic [9:0]                    mode_nxt;
    logic [9:0]                    aux_r;
    logic [9:0]                    aux_nxt;
    logic                          wr_prev_r;
    logic                          wr_take;
    logic                          coef_we;

    logic signed [dsf_pkg::CW-1:0] coef_r [dsf_pkg::COEF_DEPTH];

    logic [dsf_pkg::MODE_DEC_W-1:0] dec_nm1;
    logic                           rev_en;
    logic                           sym_en;
    logic [dsf_pkg::CELLS-1:0]      even_len;
    logic                           mixed;
    logic                           stall;

    // one word per falling strobe, so a long low pulse writes once
    assign wr_take = !config_wr_n && wr_prev_r;
    assign coef_we = wr_take && config_address_bus[dsf_pkg::AW-1];

    always_comb begin
        mode_nxt = mode_r;
        aux_nxt  = aux_r;
        // write-only words; reads are not offered on this port
        if (wr_take && config_address_bus == dsf_pkg::OFS_MODE) begin
            mode_nxt = config_data_bus;
        end
        if (wr_take && config_address_bus == dsf_pkg::OFS_AUX) begin
            aux_nxt = config_data_bus;
        end
    end

    // strobe history resets high: a strobe already low at release writes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_r    <= dsf_pkg::MODE_RST;
            aux_r     <= dsf_pkg::AUX_RST;
            wr_prev_r <= 1'b1;
        end else begin
            mode_r    <= mode_nxt;
            aux_r     <= aux_nxt;
            wr_prev_r <= config_wr_n;
        end
    end

    // coefficient bank: low eight address bits pick set and word
    always_ff @(posedge clock) begin
        if (coef_we) begin
            coef_r[config_address_bus[7:0]] <= config_data_bus;
        end
    end

    // mode bits 4, 5 and 9 carry nothing here and are ignored
    assign dec_nm1  = mode_r[dsf_pkg::MODE_DEC_LSB +:
                             dsf_pkg::MODE_DEC_W];
    assign rev_en   = !aux_r[dsf_pkg::AUX_REV_DIS_BIT];
    assign sym_en   = mode_r[dsf_pkg::MODE_SYM_BIT];
    assign even_len = {mode_r[dsf_pkg::MODE_EVEN_B_BIT],
                       mode_r[dsf_pkg::MODE_EVEN_A_BIT]};
    assign mixed    = even_len[0] != even_len[1];

    // tap k is read at the end of its N-deep decimation stage
    function automatic logic [5:0] tap_pos(input int k,
                                           input logic [3:0] nm1);
        tap_pos = 6'((k + 1) * (int'(nm1) + 1) - 1);
    endfunction : tap_pos

    // filter cells; the accumulator is the result, with no rounding stage
    logic signed [dsf_pkg::ACCW-1:0] acc_res [dsf_pkg::CELLS];

    // one cell per input stream, alike but for its coefficient half and its even-length mode bit
    for (genvar c = 0; c < dsf_pkg::CELLS; c++) begin : g_cell
        logic signed [dsf_pkg::DW-1:0]   fwd_r   [dsf_pkg::LINE_LEN];
        logic signed [dsf_pkg::DW-1:0]   fwd_nxt [dsf_pkg::LINE_LEN];
        logic signed [dsf_pkg::DW-1:0]   bwd_r   [dsf_pkg::LINE_LEN];
        logic signed [dsf_pkg::DW-1:0]   bwd_nxt [dsf_pkg::LINE_LEN];
        logic signed [dsf_pkg::DW-1:0]   lifo_r  [2][dsf_pkg::MAX_DEC];
        logic signed [dsf_pkg::DW-1:0]   lifo_nxt[2][dsf_pkg::MAX_DEC];

        logic                            wbank_r;
        logic                            wbank_nxt;
        logic [3:0]                      wptr_r;
        logic [3:0]                      wptr_nxt;
        logic [3:0]                      rptr_r;
        logic [3:0]                      rptr_nxt;
        logic                            swap_d_r;
        logic                            swap_d_nxt;
        logic                            swap_eff;

        logic signed [dsf_pkg::ACCW-1:0] acc_r;
        logic signed [dsf_pkg::ACCW-1:0] acc_nxt;

        logic signed [dsf_pkg::DW-1:0]   x_in;
        logic signed [dsf_pkg::DW-1:0]   fb;
        logic signed [dsf_pkg::DW-1:0]   lifo_rd;
        logic signed [dsf_pkg::DW-1:0]   b_in;

        logic signed [dsf_pkg::PREW-1:0] pre  [dsf_pkg::TAPS];
        logic signed [dsf_pkg::PRODW-1:0] prod[dsf_pkg::TAPS];
        logic signed [dsf_pkg::SOPW-1:0] sop;

        assign x_in = (c == 0) ? data_a_in : data_b_in;

        // odd length taps the stage ahead of the last forward register,
        // so the center sample meets itself in the pre-adder
        assign fb = even_len[c] ?
                    fwd_r[tap_pos(dsf_pkg::TAPS - 1, dec_nm1)] :
                    fwd_r[tap_pos(dsf_pkg::TAPS - 1, dec_nm1) - 6'h01];

        // odd-tap swap lags one clock behind the accumulate framing
        assign swap_eff = even_len[c] ? lifo_swap_strobe : swap_d_r;
        assign lifo_rd  = lifo_r[!wbank_r][rptr_r];
        assign b_in     = rev_en ? lifo_rd : fb;

        always_comb begin
            fwd_nxt    = fwd_r;
            bwd_nxt    = bwd_r;
            lifo_nxt   = lifo_r;
            wbank_nxt  = wbank_r;
            wptr_nxt   = wptr_r;
            rptr_nxt   = rptr_r;
            swap_d_nxt = swap_d_r;
            acc_nxt    = acc_r;
            if (!stall) begin
                fwd_nxt[0] = x_in;
                bwd_nxt[0] = b_in;
                for (int i = 1; i < dsf_pkg::LINE_LEN; i++) begin
                    fwd_nxt[i] = fwd_r[i-1];
                    bwd_nxt[i] = bwd_r[i-1];
                end
                swap_d_nxt = lifo_swap_strobe;
                // pointers saturate; a swap every N <= 16 clocks never overruns
                lifo_nxt[wbank_r][wptr_r] = fb;
                if (swap_eff) begin
                    // the block just written is read back newest first
                    wbank_nxt = !wbank_r;
                    rptr_nxt  = wptr_r;
                    wptr_nxt  = 4'h0;
                end else begin
                    if (wptr_r != 4'hF) begin
                        wptr_nxt = wptr_r + 4'h1;
                    end
                    if (rptr_r != 4'h0) begin
                        rptr_nxt = rptr_r - 4'h1;
                    end
                end
                if (accumulate_control) begin
                    acc_nxt = acc_r + dsf_pkg::ACCW'(sop);
                end else begin
                    acc_nxt = dsf_pkg::ACCW'(sop);
                end
            end
        end

        // four multipliers; asymmetric use leaves the backward term out
        always_comb begin
            sop = '0;
            for (int k = 0; k < dsf_pkg::TAPS; k++) begin
                pre[k] = dsf_pkg::PREW'(fwd_r[tap_pos(k, dec_nm1)]) +
                         (sym_en ?
                          dsf_pkg::PREW'(bwd_r[tap_pos(dsf_pkg::TAPS - 1 - k,
                                                       dec_nm1)]) :
                          dsf_pkg::PREW'(0));
                // index {set, cell, tap}: eight words a set, cell B upper half
                prod[k] = pre[k] * coef_r[{coef_set_select, 1'(c),
                                           2'(k)}];
                sop = sop + dsf_pkg::SOPW'(prod[k]);
            end
        end

        // delay lines and lifos reset too, so the first outputs are defined
        always_ff @(posedge clock) begin
            if (!rstn) begin
                for (int i = 0; i < dsf_pkg::LINE_LEN; i++) begin
                    fwd_r[i] <= '0;
                    bwd_r[i] <= '0;
                end
                for (int i = 0; i < dsf_pkg::MAX_DEC; i++) begin
                    lifo_r[0][i] <= '0;
                    lifo_r[1][i] <= '0;
                end
                wbank_r  <= 1'b0;
                wptr_r   <= 4'h0;
                rptr_r   <= 4'h0;
                swap_d_r <= 1'b0;
                acc_r    <= '0;
            end else begin
                fwd_r    <= fwd_nxt;
                bwd_r    <= bwd_nxt;
                lifo_r   <= lifo_nxt;
                wbank_r  <= wbank_nxt;
                wptr_r   <= wptr_nxt;
                rptr_r   <= rptr_nxt;
                swap_d_r <= swap_d_nxt;
                acc_r    <= acc_nxt;
            end
        end

        assign acc_res[c] = acc_r;
    end

    // output sequencing
    dsf_pkg::dsf_oseq_t           os_r;
    dsf_pkg::dsf_oseq_t           os_nxt;
    logic                         primed_r;
    logic                         primed_nxt;
    logic signed [dsf_pkg::OW-1:0] hold_r;
    logic signed [dsf_pkg::OW-1:0] hold_nxt;

    logic signed [dsf_pkg::OW-1:0] push_data;
    logic                         push_valid;
    logic                         fifo_in_ready;
    logic                         done;

    // select 2 and 3 both give the sum; each side is sign extended first
    function automatic logic signed [dsf_pkg::OW-1:0] pick(
        input logic [1:0]                    sel,
        input logic signed [dsf_pkg::ACCW-1:0] a,
        input logic signed [dsf_pkg::ACCW-1:0] b);
        unique case (sel)
            dsf_pkg::SEL_A: pick = dsf_pkg::OW'(a);
            dsf_pkg::SEL_B: pick = dsf_pkg::OW'(b);
            default:        pick = dsf_pkg::OW'(a) + dsf_pkg::OW'(b);
        endcase
    endfunction : pick

    // a full buffer with a word to push freezes the whole datapath; full alone tells the source to hold
    assign stall        = push_valid && !fifo_in_ready;
    assign sample_ready = fifo_in_ready;

    // low accumulate control opens a new sum; the held one is complete
    assign done = !accumulate_control && primed_r;

    // pushes at most one word per clock; a mixed pair takes two clocks
    always_comb begin
        os_nxt     = os_r;
        hold_nxt   = hold_r;
        primed_nxt = primed_r;
        push_valid = 1'b0;
        push_data  = hold_r;
        unique case (os_r)
            dsf_pkg::OS_IDLE: begin
                if (done) begin
                    push_valid = 1'b1;
                    push_data  = pick(output_select, acc_res[0],
                                      acc_res[1]);
                    if (mixed && output_select == dsf_pkg::SEL_A) begin
                        hold_nxt = dsf_pkg::OW'(acc_res[1]);
                    end else begin
                        hold_nxt = dsf_pkg::OW'(acc_res[0]);
                    end
                    if (mixed && fifo_in_ready) begin
                        os_nxt = dsf_pkg::OS_SECOND;
                    end
                end
            end
            // second mixed word waits in hold until the buffer takes it
            dsf_pkg::OS_SECOND: begin
                push_valid = 1'b1;
                push_data  = hold_r;
                if (fifo_in_ready) begin
                    os_nxt = dsf_pkg::OS_IDLE;
                end
            end
        endcase
        // stall spelt out: reading the stall net would loop onto push_valid
        if (fifo_in_ready || !push_valid) begin
            primed_nxt = 1'b1;
        end
        if (!fifo_in_ready && os_r == dsf_pkg::OS_IDLE) begin
            hold_nxt = hold_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            os_r     <= dsf_pkg::OS_IDLE;
            hold_r   <= '0;
            primed_r <= 1'b0;
        end else begin
            os_r     <= os_nxt;
            hold_r   <= hold_nxt;
            primed_r <= primed_nxt;
        end
    end

    // buffer absorbs sink back-pressure; once full with a word to push, the whole datapath waits
    dsf_fifo #(
        .W     (dsf_pkg::OW),
        .DEPTH (dsf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (out_data),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );
endmodule : dsf_decim_fir

// ### dv/dsf_decim_fir_checker.sv
// port-level assertions for the decimating filter
`timescale 1ns/1ps
module dsf_decim_fir_checker (
    input wire logic                   clock,              // clock
    input wire logic                   rstn,               // sync, low
    input wire logic                   sample_ready,       // low: hold
    input wire logic                   accumulate_control, // high: sum on
    input wire logic [dsf_pkg::OW-1:0] out_data,           // result word
    input wire logic                   out_valid,          // word ready
    input wire logic                   out_ready           // sink takes
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_rst_idle: assert property ($rose(rstn) |-> !out_valid)
        else $error("output valid right after reset");
    chk_word_holds: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("unaccepted word changed or vanished");
    chk_push_cause: assert property ($rose(out_valid) |->
        !$past(accumulate_control) || !$past(accumulate_control, 2))
        else $error("word appeared without a finished sum");
    chk_full_nonempty: assert property (
        !sample_ready |-> out_valid)
        else $error("stall while buffer empty");
    chk_full_stays: assert property (
        !sample_ready && !out_ready |=> !sample_ready)
        else $error("full buffer freed without a pop");
    chk_pop_frees: assert property (
        !sample_ready && out_ready |=> sample_ready)
        else $error("pop did not free room");
    chk_acc_each: assert property (
        (!accumulate_control && sample_ready)[*3] |=> out_valid)
        else $error("standalone sums not emitted");
    chk_quiet_idle: assert property (
        !out_valid && accumulate_control |=> !out_valid)
        else $error("word emitted mid accumulation");
endmodule : dsf_decim_fir_checker

bind dsf_decim_fir dsf_decim_fir_checker i_chk (
    .clock(clock),
    .rstn(rstn),
    .sample_ready(sample_ready),
    .accumulate_control(accumulate_control),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready)
);

// ### dv/dsf_ctl_model.sv
// control sequencer: swap strobe, accumulate control, set stepping
`timescale 1ns/1ps
module dsf_ctl_model (
    input  wire logic       clock,        // clock
    input  wire logic       rstn,         // sync reset, low
    input  wire logic       run,          // sequencing on
    input  wire logic [3:0] nm1,          // decimation minus one
    input  wire logic       sample_ready, // low: hold everything
    output logic            swap,         // lifo swap strobe
    output logic            acc,          // accumulate control
    output logic [4:0]      cset          // coefficient set
);
    logic [3:0] ph_r;
    logic [3:0] ph_nxt;

    always_comb begin
        ph_nxt = ph_r;
        if (!run) begin
            ph_nxt = 4'h0;
        end else if (sample_ready) begin
            ph_nxt = (ph_r == nm1) ? 4'h0 : ph_r + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        ph_r <= rstn ? ph_nxt : 4'h0;
    end

    // phase zero starts each block; idle keeps summing, never emits
    assign swap = run && ph_r == 4'h0;
    assign acc  = !(run && ph_r == 4'h0);
    assign cset = {1'b0, ph_r};
endmodule : dsf_ctl_model

// ### dv/dsf_decim_fir_test.sv
// self-checking bench for the decimating filter
`timescale 1ns/1ps
module dsf_decim_fir_test;
    logic                   clock = 1'b0;
    logic                   rstn = 1'b0;
    logic [dsf_pkg::DW-1:0] data_a_in = '0;
    logic [dsf_pkg::DW-1:0] data_b_in = '0;
    logic                   sample_ready;
    logic                   swap;
    logic                   acc;
    logic [4:0]             cset;
    logic [1:0]             sel = 2'h0;
    logic [9:0]             cfg_data = '0;
    logic [8:0]             cfg_addr = '0;
    logic                   cfg_wr_n = 1'b1;
    logic [dsf_pkg::OW-1:0] out_data;
    logic                   out_valid;
    logic                   out_ready = 1'b1;
    logic                   run = 1'b0;
    logic [3:0]             nm1 = 4'h0;
    logic                   armed = 1'b0;
    int                     n_mismatch = 0;
    int                     samples_checked = 0;
    int                     seed = 3979;
    int                     ev1 = 0;
    int                     coef [3][2][4];
    logic [dsf_pkg::OW-1:0] exp_q [$];

    always #5 clock = ~clock;

    dsf_decim_fir i_dut (
        .clock(clock), .rstn(rstn),
        .data_a_in(data_a_in), .data_b_in(data_b_in),
        .sample_ready(sample_ready),
        .lifo_swap_strobe(swap), .accumulate_control(acc),
        .coef_set_select(cset), .output_select(sel),
        .config_data_bus(cfg_data), .config_address_bus(cfg_addr),
        .config_wr_n(cfg_wr_n),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready)
    );

    dsf_ctl_model i_ctl (
        .clock(clock), .rstn(rstn), .run(run), .nm1(nm1),
        .sample_ready(sample_ready), .swap(swap), .acc(acc), .cset(cset)
    );

    task automatic end_sim;
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [dsf_pkg::OW-1:0] seen,
                         input logic [dsf_pkg::OW-1:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check

    task automatic note(input int v);
        exp_q.push_back(v[dsf_pkg::OW-1:0]);
    endtask : note

    task automatic cfg_write(input logic [8:0] a, input logic [9:0] d);
        @(posedge clock);
        cfg_addr <= a;
        cfg_data <= d;
        cfg_wr_n <= 1'b0;
        @(posedge clock);
        cfg_wr_n <= 1'b1;
    endtask : cfg_write

    task automatic wait_drain(input int lim);
        for (int i = 0; i < lim && exp_q.size() > 0; i++) begin
            @(posedge clock);
        end
        if (exp_q.size() > 0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, 0, exp_q[0]);
            end_sim();
        end else begin
            armed = 1'b0;
        end
    endtask : wait_drain

    // constant input: every path settles to x, so timing drops out
    function automatic int cell_sum(input int c, input logic [9:0] m,
                                    input int x);
        int s;
        s = 0;
        for (int k = 0; k <= int'(m[3:0]); k++) begin
            for (int t = 0; t < 4; t++) begin
                s += coef[k][c][t];
            end
        end
        return s * x * (m[8] ? 2 : 1);
    endfunction : cell_sum

    function automatic int pick(input logic [1:0] s, input int a,
                                input int b);
        return (s == 2'h0) ? a : (s == 2'h1) ? b : a + b;
    endfunction : pick

    task automatic run_case(input logic [9:0] m, input logic [1:0] s);
        int xa;
        int xb;
        int va;
        int vb;
        run <= 1'b0;
        nm1 <= m[3:0];
        cfg_write(dsf_pkg::OFS_MODE, m);
        // no decimation means no reversal; decimating runs need it on
        cfg_write(dsf_pkg::OFS_AUX,
                  (m[3:0] == 4'h0) ? 10'h010 : 10'h000);
        cfg_write(9'h002, 10'h3FF);
        xa = $random(seed) % 512;
        xb = $random(seed) % 512;
        @(posedge clock);
        data_a_in <= xa[9:0];
        data_b_in <= xb[9:0];
        sel <= s;
        run <= 1'b1;
        repeat (60) @(posedge clock);
        va = cell_sum(0, m, xa);
        vb = cell_sum(1, m, xb);
        ev1 = pick(s, va, vb);
        // stop on the edge that pushes a block's first word, arm after it
        for (int i = 0; i < 20 && acc !== 1'b0; i++) begin
            @(posedge clock);
        end
        if (acc !== 1'b0) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, acc, 1'b0);
            end_sim();
        end
        #1 armed = 1'b1;
        repeat (4) begin
            note(ev1);
            if (m[6] != m[7]) note(s == 2'h0 ? vb : va);
        end
        wait_drain(200);
    endtask : run_case

    always @(posedge clock) begin
        if (out_valid === 1'b1 && out_ready && armed && exp_q.size() > 0)
        begin
            check(out_data, exp_q.pop_front());
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 2; c++) begin
                for (int t = 0; t < 4; t++) begin
                    int a;
                    a = 256 + k * 8 + c * 4 + t;
                    coef[k][c][t] = $random(seed) % 512;
                    // center word stored halved for the odd-length runs
                    if (k == 0 && t == 3) begin
                        coef[k][c][t] = coef[k][c][t] / 2;
                    end
                    cfg_write(a[8:0], coef[k][c][t][9:0]);
                end
            end
        end
        cfg_write(9'h0FF, 10'h3FF);
        run_case(10'h000, 2'h0);
        run_case(10'h000, 2'h2);
        run_case(10'h1D2, 2'h1);
        run_case(10'h112, 2'h2);
        run_case(10'h152, 2'h1);
        run_case(10'h152, 2'h0);
        run_case(10'h000, 2'h1);
        // stall the sink until the buffer refuses, then drain it
        out_ready <= 1'b0;
        repeat (40) @(posedge clock);
        check({{(dsf_pkg::OW - 1){1'b0}}, sample_ready}, '0);
        armed = 1'b1;
        repeat (dsf_pkg::FIFO_DEPTH) note(ev1);
        out_ready <= 1'b1;
        wait_drain(100);
        end_sim();
    end
endmodule : dsf_decim_fir_test
